//--- design/lpeac_regs.vh
/*
  Constants for the leaf page entry access check: entry field positions,
  memory type codes, translation kinds, fault record field positions.
  Assumes inclusion by bare name from the design files.
*/
`ifndef LPEAC_REGS_VH
`define LPEAC_REGS_VH

// Leaf entry low bits
`define LPEAC_ENT_READ_BIT      0
`define LPEAC_ENT_WRITE_BIT     1
`define LPEAC_ENT_EXEC_BIT      2
`define LPEAC_ENT_EMT_LO        3
`define LPEAC_ENT_EMT_HI        5
`define LPEAC_ENT_OVR_BIT       6

// Extended memory type codes
`define LPEAC_MT_UC             3'h0
`define LPEAC_MT_WC             3'h1
`define LPEAC_MT_WT             3'h4
`define LPEAC_MT_WP             3'h5
`define LPEAC_MT_WB             3'h6

// Table mode and translation kind codes
`define LPEAC_TTM_LEGACY        2'h0
`define LPEAC_PASID_TRANSLATION_KIND_SECOND       3'h2
`define LPEAC_PASID_TRANSLATION_KIND_NESTED       3'h3

// Request kinds
`define LPEAC_REQ_READ          2'h0
`define LPEAC_REQ_WRITE         2'h1
`define LPEAC_REQ_ATOMIC        2'h2
`define LPEAC_REQ_EXEC          2'h3

// Fault record fields (within bits 127:124)
`define LPEAC_FR_TYPE_BIT       126
`define LPEAC_FR_AT_LO          124
`define LPEAC_FR_AT_HI          125

// Fault cause code for a permission denial
`define LPEAC_CAUSE_PERM        8'h05

`endif

//--- design/lpeac_fault_hold.v
/*
  Holds the upper fault record nibble and cause code of the last fault.
  Assumes an active-low reset, asserted asynchronously and released in step with clk by the top.
*/
module lpeac_fault_hold (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_sync_n,
  // Capture
  input  wire       cap_en,
  input  wire [3:0] cap_nibble,
  input  wire [7:0] cap_cause,
  // Held record
  output reg  [3:0] held_nibble,
  output reg  [7:0] held_cause
);

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      held_nibble <= 4'h0;
      held_cause  <= 8'h00;
    end else if (cap_en) begin
      held_nibble <= cap_nibble;
      held_cause  <= cap_cause;
    end
  end

endmodule

//--- design/lpeac_check.v
/*
  Access check on the low bits of a second level leaf entry for a 4-KByte
  page, effective memory type selection, and the type and address-kind
  fields of the fault record.
  Assumes requests and configuration are synchronous to clk and stable
  while req_valid is high; one request is judged per cycle.
*/
// Contract
// [R1] Override bit honoured only under four conditions
// [R2] Override 0 uses attribute table, 1 excludes
// [R3] Memory type codes UC WC WT WP WB
// [R4] Memory type used only when enabled, scalable
// [R5] Execute denied when enforced and bit clear
// [R6] Write denied when write bit clear
// [R7] Read denied when read bit clear
// [R8] Zero-length read exempt when write/execute set
// [R9] Fault type bit: 0 write, 1 read/atomic
// [R10] Fault address kind copied, zero without TLB
// [R11] Denied access becomes non-recoverable fault record
`include "lpeac_regs.vh"

module lpeac_check #(
  parameter DEVICE_TLB_SUPPORT     = 1,
  parameter ZERO_LENGTH_READ_SUPPORT = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // Configuration from the PASID entry and global state
  input  wire         extended_memtype_enable,
  input  wire [1:0]   table_mode_select,
  input  wire [2:0]   pasid_translation_kind,
  input  wire         second_level_execute_enforce,
  // Request
  input  wire         req_valid,
  input  wire [1:0]   req_kind,
  input  wire         req_zero_length,
  input  wire         req_coherent,
  input  wire [1:0]   req_addr_kind,
  input  wire [6:0]   second_level_leaf_entry,
  // Verdict
  output reg          resp_valid,
  output reg          resp_grant,
  output reg          resp_fault,
  output reg          resp_mt_valid,
  output reg  [2:0]   resp_mem_type,
  output reg          resp_mt_reserved,
  output reg          resp_use_attr_table,
  // Fault record fields
  output reg          fault_valid,
  output wire [127:124] fault_record_hi,
  output wire [7:0]   fault_cause_code
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  reg rst_meta_reg;
  reg rst_sync_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire       bit_read   = second_level_leaf_entry[`LPEAC_ENT_READ_BIT];
  wire       bit_write  = second_level_leaf_entry[`LPEAC_ENT_WRITE_BIT];
  wire       bit_exec   = second_level_leaf_entry[`LPEAC_ENT_EXEC_BIT];
  wire [2:0] extended_memory_type =
    second_level_leaf_entry[`LPEAC_ENT_EMT_HI:`LPEAC_ENT_EMT_LO];
  wire       attribute_table_override = second_level_leaf_entry[`LPEAC_ENT_OVR_BIT];

  wire scalable = (table_mode_select != `LPEAC_TTM_LEGACY);
  wire nested   = (pasid_translation_kind == `LPEAC_PASID_TRANSLATION_KIND_NESTED);
  wire second   = (pasid_translation_kind == `LPEAC_PASID_TRANSLATION_KIND_SECOND);

  wire ovr_applies = extended_memtype_enable & scalable & nested & req_coherent; // [R1]
  wire use_table   = ~(ovr_applies & attribute_table_override); // [R2]
  wire mt_applies  = extended_memtype_enable & scalable & (second | nested)
                   & req_coherent; // [R4]

  reg mt_rsvd;
  always @* begin
    case (extended_memory_type) // [R3]
      `LPEAC_MT_UC,
      `LPEAC_MT_WC,
      `LPEAC_MT_WT,
      `LPEAC_MT_WP,
      `LPEAC_MT_WB: mt_rsvd = 1'b0;
      default:      mt_rsvd = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Permission check
  wire zlr_exempt = (ZERO_LENGTH_READ_SUPPORT != 0) & req_zero_length
                  & (bit_write | bit_exec); // [R8]

  reg deny;
  always @* begin
    case (req_kind)
      `LPEAC_REQ_READ:   deny = ~bit_read & ~zlr_exempt; // [R7]
      `LPEAC_REQ_WRITE:  deny = ~bit_write; // [R6]
      `LPEAC_REQ_ATOMIC: deny = ~bit_read | ~bit_write;
      `LPEAC_REQ_EXEC:   deny = (~bit_read & ~zlr_exempt)
                              | (second_level_execute_enforce & ~bit_exec); // [R5]
      default:           deny = 1'b1;
    endcase
  end

  wire       is_write  = (req_kind == `LPEAC_REQ_WRITE);
  wire       type_bit  = ~is_write; // [R9]
  wire [1:0] at_field  = (DEVICE_TLB_SUPPORT != 0) ? req_addr_kind : 2'h0; // [R10]

  ////////////////////////////////////////////////////////////////////////
  // Registered verdict
  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      resp_valid          <= 1'b0;
      resp_grant          <= 1'b0;
      resp_fault          <= 1'b0;
      resp_mt_valid       <= 1'b0;
      resp_mem_type       <= 3'h0;
      resp_mt_reserved    <= 1'b0;
      resp_use_attr_table <= 1'b1;
      fault_valid         <= 1'b0;
    end else begin
      resp_valid          <= req_valid;
      resp_grant          <= req_valid & ~deny;
      resp_fault          <= req_valid & deny; // [R11]
      resp_mt_valid       <= req_valid & mt_applies;
      resp_mem_type       <= mt_applies ? extended_memory_type : 3'h0;
      resp_mt_reserved    <= req_valid & mt_applies & mt_rsvd;
      resp_use_attr_table <= use_table;
      fault_valid         <= req_valid & deny; // [R11]
    end
  end

  wire [3:0] rec_nibble = {1'b0, type_bit, at_field[1:0]};

  lpeac_fault_hold u_hold (
    .clk         (clk),
    .rst_sync_n  (rst_sync_reg),
    .cap_en      (req_valid & deny),
    .cap_nibble  (rec_nibble),
    .cap_cause   (`LPEAC_CAUSE_PERM),
    .held_nibble (fault_record_hi),
    .held_cause  (fault_cause_code)
  );

endmodule

//--- tb/lpeac_check_asserts.sv
/* Checker for the leaf entry access check, bound to lpeac_check.
   Assumes the top ports only; one clock, rst_n as disable. */
module lpeac_check_asserts (
  input wire           clk, rst_n, extended_memtype_enable, second_level_execute_enforce,
  input wire           req_valid, req_zero_length, req_coherent, resp_valid, resp_grant,
  input wire           resp_fault, resp_mt_valid, resp_use_attr_table, fault_valid,
  input wire [1:0]     table_mode_select, req_kind, req_addr_kind,
  input wire [2:0]     pasid_translation_kind, resp_mem_type,
  input wire [6:0]     second_level_leaf_entry,
  input wire [127:124] fault_record_hi
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [6:0] e = second_level_leaf_entry;
  wire       zl_ok = req_zero_length && (e[1] || e[2]);
  wire       rd = req_valid && req_kind == 2'h0;
  a_one_answer: assert property (req_valid |=> resp_valid && (resp_grant ^ resp_fault))
    else $error("no single verdict");
  a_no_spurious: assert property (!req_valid |=> !resp_valid && !fault_valid)
    else $error("verdict without request");
  a_write_deny: assert property (req_valid && req_kind == 2'h1 && !e[1] |=> resp_fault)
    else $error("write not denied");
  a_read_deny: assert property (rd && !e[0] && !zl_ok |=> resp_fault)
    else $error("read not denied");
  a_zlr_exempt: assert property (rd && zl_ok |=> resp_grant)
    else $error("zero-length read denied");
  a_exec_deny: assert property (req_valid && req_kind == 2'h3 && second_level_execute_enforce
    && !e[2] |=> resp_fault)
    else $error("execute not denied");
  a_fault_type: assert property (fault_valid |-> resp_fault
    && fault_record_hi[126] == ($past(req_kind) != 2'h1))
    else $error("fault type wrong");
  a_fault_addr: assert property (fault_valid |-> fault_record_hi[125:124]
    == $past(req_addr_kind))
    else $error("fault address kind wrong");
  a_mt_gate: assert property (req_valid && (!extended_memtype_enable
    || table_mode_select == 2'h0 || !req_coherent) |=> !resp_mt_valid)
    else $error("memory type applied");
  a_mt_code: assert property (resp_mt_valid |-> resp_mem_type == $past(e[5:3]))
    else $error("memory type code wrong");
  a_attr_table: assert property (req_valid && extended_memtype_enable && table_mode_select
    != 2'h0 && pasid_translation_kind == 3'h3 && req_coherent
    |=> resp_use_attr_table == !$past(e[6]))
    else $error("attribute table choice wrong");
endmodule
bind lpeac_check lpeac_check_asserts chk_u (.*);

//--- tb/lpeac_req_src.sv
/* Requesting device model: one request pulse per call of issue.
   Assumes calls from the bench; kind, address kind and entry lines are inverted once released. */
module lpeac_req_src (
  input  wire        clk,
  output logic       req_valid = 1'b0, req_zero_length = 1'b0, req_coherent = 1'b1,
  output logic [1:0] req_kind = 2'h0, req_addr_kind = 2'h0,
  output logic [6:0] second_level_leaf_entry = 7'h00
);
  task automatic issue(input [1:0] k, input z, input [1:0] a, input [6:0] e);
    @(posedge clk);
    req_valid <= 1'b1;
    {req_kind, req_zero_length, req_addr_kind, second_level_leaf_entry} <= {k, z, a, e};
    @(posedge clk);
    req_valid <= 1'b0;
    {req_kind, req_addr_kind, second_level_leaf_entry} <= ~{k, a, e};
  endtask
endmodule

//--- tb/lpeac_check_bench.sv
/* Bench for the leaf entry access check: one task per scenario.
   Assumes lpeac_req_src as requester and the bound checker. */
`define CK(n,e,s) begin n_checks++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module lpeac_check_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, extended_memtype_enable = 0, second_level_execute_enforce = 0;
  logic [1:0]     table_mode_select = 2'h1;
  logic [2:0]     pasid_translation_kind = 3'h2;
  wire            req_valid, req_zero_length, req_coherent, resp_valid, resp_grant;
  wire            resp_fault, resp_mt_valid, resp_mt_reserved, resp_use_attr_table;
  wire            fault_valid;
  wire [1:0]      req_kind, req_addr_kind;
  wire [6:0]      second_level_leaf_entry;
  wire [2:0]      resp_mem_type;
  wire [127:124]  fault_record_hi;
  wire [7:0]      fault_cause_code;
  int             fails = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  lpeac_check dut_u (.*);
  lpeac_req_src src_u (.*);
  task automatic rq(input [1:0] k, a, input z, input [6:0] e, input g);
    src_u.issue(k, z, a, e);
    #1;
    `CK("valid", 1'b1, resp_valid)
    `CK("grant", g, resp_grant)
    `CK("fault", !g, fault_valid)
    if (!g) `CK("record", {1'b0, k != 2'h1, a}, fault_record_hi)
    if (!g) `CK("cause", 8'h05, fault_cause_code)
  endtask
  task t_perm;
    rq(2'h1, 2'h2, 0, 7'h05, 0);
    rq(2'h1, 2'h1, 0, 7'h02, 1);
    rq(2'h2, 2'h3, 0, 7'h01, 0);
    rq(2'h0, 2'h3, 0, 7'h06, 0);
    rq(2'h0, 2'h0, 1, 7'h02, 1);
    rq(2'h0, 2'h1, 1, 7'h00, 0);
    rq(2'h3, 2'h1, 0, 7'h01, 1);
    @(posedge clk);
    second_level_execute_enforce <= 1'b1;
    rq(2'h3, 2'h1, 0, 7'h01, 0);
    rq(2'h3, 2'h2, 0, 7'h05, 1);
    $display("t_perm done");
  endtask
  task t_mtype;
    @(posedge clk);
    extended_memtype_enable <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      rq(2'h0, 2'h0, 0, {1'b0, c[2:0], 3'h1}, 1);
      `CK("mtype", c[2:0], resp_mem_type)
      `CK("mtres", 1'(c inside {2, 3, 7}), resp_mt_reserved)
      `CK("mtval", 1'b1, resp_mt_valid)
    end
    @(posedge clk);
    table_mode_select <= 2'h0;
    rq(2'h0, 2'h0, 0, 7'h29, 1);
    `CK("mtval", 1'b0, resp_mt_valid)
    $display("t_mtype done");
  endtask
  task t_attr;
    @(posedge clk);
    table_mode_select <= 2'h1;
    pasid_translation_kind <= 3'h3;
    rq(2'h0, 2'h0, 0, 7'h41, 1);
    `CK("attr", 1'b0, resp_use_attr_table)
    rq(2'h0, 2'h0, 0, 7'h01, 1);
    `CK("attr", 1'b1, resp_use_attr_table)
    @(posedge clk);
    src_u.req_coherent <= 1'b0;
    rq(2'h0, 2'h0, 0, 7'h41, 1);
    `CK("attr", 1'b1, resp_use_attr_table)
    `CK("mtval", 1'b0, resp_mt_valid)
    @(posedge clk);
    src_u.req_coherent <= 1'b1;
    pasid_translation_kind <= 3'h2;
    rq(2'h0, 2'h0, 0, 7'h41, 1);
    `CK("attr", 1'b1, resp_use_attr_table)
    $display("t_attr done");
  endtask
  task end_sim;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_perm;
    t_mtype;
    t_attr;
    end_sim;
  end
endmodule
